// File: core/port_alt_function_mux.sv
// Alternate-function pin multiplexer for ports 5 to 9
// Operation
// R1 - Port 5.3 alternate: 00 key 3, 01 B0ch0 in, 10 B0ch0 out, 11 motor B2
// R2 - Debug takeover: 5.3 debug data out, 5.4 clock in, 5.5 mode in
// R3 - Port 5.4 alternate: 00 key-return 4, 11 motor top phase 3
// R4 - Port 5.5 alternate: 00 key-return 5, 11 motor bottom phase 3
// R5 - Port 6.0-6.2 with mode and low select: interrupts 11 to 13
// R6 - Port 6.10-6.13: timer B2 channels 0-3, low select 0 in, 1 out
// R7 - Port 7 pins become analogue inputs 0-15 when mode set
// R8 - Port 8.0 UART3 receive and interrupt 14; 8.1 UART3 transmit
// R9 - Software disables interrupt 14 edges on port 4 when UART3 receives
// R10 - Software disables interrupt 14 edges on port 8 when UART3 receives
// R11 - Software keeps UART3 receiver off while pin serves interrupt 14
// R12 - Port 9.0 alternate: 01 key-return 6, 10 UART1 transmit
// R13 - Port 9.1 alternate: 01 key-return 7, 10 UART1 receive plus key 7
// R14 - Software never uses UART1 receive and key-return 7 together
// R15 - Port 9.2-9.5: timer B1 ch 1,2,3,0; 01 in, 10 out
// R16 - Port 9.6 alternate: 10 timer A2 ch1 in, 11 its output
// R17 - Port 9.7 alternate: 01 serial data in, 10 A2 ch0 in, 11 out
// R18 - Port 9.8 alternate: 01 serial data out, 10 B0 ch3 in, 11 out
// R19 - Port 9.9 alternate: 01 serial clock, 10 B0 ch0 in, 11 out
// R20 - Alternate pin: peripheral owns direction and level, port bits ignored
// R21 - Software sets selects, then mode bit, then pull-up
// R22 - Port mode pin driven by port latch and direction bits
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module port_alt_function_mux (
    input  wire logic                            CLK_SYS,
    input  wire logic                            RST_B,
    input  wire logic                            CE,
    input  wire logic [pin_mux_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [pin_mux_pkg::DATA_W-1:0]  WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output var  logic [pin_mux_pkg::DATA_W-1:0]  RDATA,
    input  wire logic [pin_mux_pkg::PIN_W-1:0]   PAD_IN,
    output var  logic [pin_mux_pkg::PIN_W-1:0]   PAD_OUT,
    output var  logic [pin_mux_pkg::PIN_W-1:0]   PAD_OE,
    input  wire logic                            TIMER_B0_CH0_OUTPUT,
    input  wire logic                            TIMER_B0_CH3_OUTPUT,
    input  wire logic                            MOTOR_BOTTOM_PHASE2_OUT,
    input  wire logic                            MOTOR_TOP_PHASE3_OUT,
    input  wire logic                            MOTOR_BOTTOM_PHASE3_OUT,
    input  wire logic [3:0]                      TIMER_B1_CH_OUTPUT,
    input  wire logic [3:0]                      TIMER_B2_CH_OUTPUT,
    input  wire logic                            TIMER_A2_CH0_OUTPUT,
    input  wire logic                            TIMER_A2_CH1_OUTPUT,
    input  wire logic                            UART1_TRANSMIT_PIN,
    input  wire logic                            UART3_TRANSMIT_PIN,
    input  wire logic                            CSI1_DATA_OUT,
    input  wire logic                            CSI1_SERIAL_CLOCK_OUT,
    input  wire logic                            CSI1_SERIAL_CLOCK_OE,
    input  wire logic                            DEBUG_DATA_OUT,
    output var  logic [7:0]                      KEY_RETURN,
    output var  logic                            TIMER_B0_CH0_INPUT,
    output var  logic                            TIMER_B0_CH3_INPUT,
    output var  logic [3:0]                      TIMER_B1_CH_INPUT,
    output var  logic [3:0]                      TIMER_B2_CH_INPUT,
    output var  logic                            TIMER_A2_CH0_INPUT,
    output var  logic                            TIMER_A2_CH1_INPUT,
    output var  logic                            UART1_RECEIVE_PIN,
    output var  logic                            UART3_RECEIVE_PIN,
    output var  logic [3:0]                      EXT_INTERRUPT,
    output var  logic                            CSI1_DATA_IN,
    output var  logic                            CSI1_SERIAL_CLOCK_IN,
    output var  logic                            DEBUG_CLOCK_IN,
    output var  logic                            DEBUG_MODE_SELECT_IN,
    output var  logic [15:0]                     ANALOG_INPUT_SEL,
    output var  logic                            DEBUG_PIN_TAKEOVER
);

    localparam int P5 = pin_mux_pkg::BASE_P5;
    localparam int P6 = pin_mux_pkg::BASE_P6;
    localparam int P7 = pin_mux_pkg::BASE_P7;
    localparam int P8 = pin_mux_pkg::BASE_P8;
    localparam int P9 = pin_mux_pkg::BASE_P9;
    localparam int PW = pin_mux_pkg::PORT_W;

    logic [PW-1:0]                   alt_mode_select_reg  [pin_mux_pkg::NUM_PORT];
    logic [PW-1:0]                   func_select_low_reg  [pin_mux_pkg::NUM_PORT];
    logic [PW-1:0]                   func_select_high_reg [pin_mux_pkg::NUM_PORT];
    logic [PW-1:0]                   pin_direction_reg    [pin_mux_pkg::NUM_PORT];
    logic [PW-1:0]                   port_output_latch_reg[pin_mux_pkg::NUM_PORT];
    logic [pin_mux_pkg::PIN_W-1:0]   mode_vec;
    logic [pin_mux_pkg::PIN_W-1:0]   fsl_vec;
    logic [pin_mux_pkg::PIN_W-1:0]   fsh_vec;
    logic [pin_mux_pkg::PIN_W-1:0]   dir_vec;
    logic [pin_mux_pkg::PIN_W-1:0]   latch_vec;
    logic [pin_mux_pkg::PIN_W-1:0]   level_vec;
    logic [pin_mux_pkg::PIN_W-1:0]   alt_sel;
    logic [pin_mux_pkg::PIN_W-1:0]   alt_out;
    logic [pin_mux_pkg::PIN_W-1:0]   alt_oe;
    logic                            debug_pin_takeover_reg;
    logic [2:0]                      slot;
    logic [4:0]                      field;
    logic                            slot_hit;
    logic [PW-1:0]                   wmask;
    logic [pin_mux_pkg::DATA_W-1:0]  rdata_next;

    assign slot     = ADDR[7:5];
    assign field    = ADDR[4:0];
    assign slot_hit = (slot <= pin_mux_pkg::SLOT_P9);
    assign wmask    = slot_hit ? pin_mux_pkg::PIN_PRESENT[slot*PW +: PW]
                               : 16'h0000;

    function automatic pin_mux_pkg::fsel_t pair(input int idx);
        pair = pin_mux_pkg::fsel_t'({fsh_vec[idx], fsl_vec[idx]});
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < pin_mux_pkg::NUM_PORT; gp++) begin : g_flat
            assign mode_vec [gp*PW +: PW] = alt_mode_select_reg[gp];
            assign fsl_vec  [gp*PW +: PW] = func_select_low_reg[gp];
            assign fsh_vec  [gp*PW +: PW] = func_select_high_reg[gp];
            assign dir_vec  [gp*PW +: PW] = pin_direction_reg[gp];
            assign latch_vec[gp*PW +: PW] = port_output_latch_reg[gp];
        end
    endgenerate

    // Port configuration writes; absent pins stay at reset value
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            for (int i = 0; i < pin_mux_pkg::NUM_PORT; i++) begin
                alt_mode_select_reg[i]   <= pin_mux_pkg::RST_MODE;
                func_select_low_reg[i]   <= pin_mux_pkg::RST_FSEL;
                func_select_high_reg[i]  <= pin_mux_pkg::RST_FSEL;
                pin_direction_reg[i]     <= pin_mux_pkg::RST_DIR;
                port_output_latch_reg[i] <= pin_mux_pkg::RST_LATCH;
            end
        end else if (CE && WR && slot_hit) begin
            case (field)
                pin_mux_pkg::OFS_MODE: alt_mode_select_reg[slot] <=
                    (alt_mode_select_reg[slot] & ~wmask) | (WDATA[15:0] & wmask);
                pin_mux_pkg::OFS_FSL: func_select_low_reg[slot] <=
                    (func_select_low_reg[slot] & ~wmask) | (WDATA[15:0] & wmask);
                pin_mux_pkg::OFS_FSH: func_select_high_reg[slot] <=
                    (func_select_high_reg[slot] & ~wmask) | (WDATA[15:0] & wmask);
                pin_mux_pkg::OFS_DIR: pin_direction_reg[slot] <=
                    (pin_direction_reg[slot] & ~wmask) | (WDATA[15:0] & wmask);
                pin_mux_pkg::OFS_LATCH: port_output_latch_reg[slot] <=
                    (port_output_latch_reg[slot] & ~wmask)
                    | (WDATA[15:0] & wmask);
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            debug_pin_takeover_reg <= pin_mux_pkg::RST_DEBUG;
        end else if (CE && WR && ADDR == pin_mux_pkg::OFS_DEBUG) begin
            debug_pin_takeover_reg <= WDATA[0];
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_comb begin
        rdata_next = '0;
        if (ADDR == pin_mux_pkg::OFS_DEBUG) begin
            rdata_next[0] = debug_pin_takeover_reg;
        end else if (slot_hit) begin
            case (field)
                pin_mux_pkg::OFS_MODE:  rdata_next[15:0] = alt_mode_select_reg[slot];
                pin_mux_pkg::OFS_FSL:   rdata_next[15:0] = func_select_low_reg[slot];
                pin_mux_pkg::OFS_FSH:   rdata_next[15:0] = func_select_high_reg[slot];
                pin_mux_pkg::OFS_DIR:   rdata_next[15:0] = pin_direction_reg[slot];
                pin_mux_pkg::OFS_LATCH: rdata_next[15:0] = port_output_latch_reg[slot];
                pin_mux_pkg::OFS_LEVEL: rdata_next[15:0] = level_vec[slot*PW +: PW]
                                                         & wmask;
                default:                rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            RDATA <= '0;
        end else if (CE) begin
            RDATA <= RD ? rdata_next : '0;
        end
    end

    // Pad ownership and drive for each alternate function
    always_comb begin
        alt_sel = mode_vec & pin_mux_pkg::PIN_PRESENT;          // [R20]
        alt_out = '0;
        alt_oe  = '0;
        case (pair(P5+3))
            pin_mux_pkg::SEL_10: begin
                alt_out[P5+3] = TIMER_B0_CH0_OUTPUT;            // [R1]
                alt_oe[P5+3]  = 1'b1;
            end
            pin_mux_pkg::SEL_11: begin
                alt_out[P5+3] = MOTOR_BOTTOM_PHASE2_OUT;        // [R1]
                alt_oe[P5+3]  = 1'b1;
            end
            default: ;
        endcase
        if (pair(P5+4) == pin_mux_pkg::SEL_11) begin
            alt_out[P5+4] = MOTOR_TOP_PHASE3_OUT;               // [R3]
            alt_oe[P5+4]  = 1'b1;
        end
        if (pair(P5+5) == pin_mux_pkg::SEL_11) begin
            alt_out[P5+5] = MOTOR_BOTTOM_PHASE3_OUT;            // [R4]
            alt_oe[P5+5]  = 1'b1;
        end
        for (int c = 0; c < 4; c++) begin
            alt_out[P6+10+c] = TIMER_B2_CH_OUTPUT[c];           // [R6]
            alt_oe[P6+10+c]  = fsl_vec[P6+10+c];                // [R6]
        end
        alt_out[P8+1] = UART3_TRANSMIT_PIN;                     // [R8]
        alt_oe[P8+1]  = 1'b1;
        if (pair(P9) == pin_mux_pkg::SEL_10) begin
            alt_out[P9] = UART1_TRANSMIT_PIN;                   // [R12]
            alt_oe[P9]  = 1'b1;
        end
        // Pins 9.2..9.5 carry channels 1, 2, 3, 0
        for (int c = 0; c < 4; c++) begin
            if (pair(P9+2+c) == pin_mux_pkg::SEL_10) begin
                alt_out[P9+2+c] = TIMER_B1_CH_OUTPUT[(c+1)%4];  // [R15]
                alt_oe[P9+2+c]  = 1'b1;
            end
        end
        if (pair(P9+6) == pin_mux_pkg::SEL_11) begin
            alt_out[P9+6] = TIMER_A2_CH1_OUTPUT;                // [R16]
            alt_oe[P9+6]  = 1'b1;
        end
        if (pair(P9+7) == pin_mux_pkg::SEL_11) begin
            alt_out[P9+7] = TIMER_A2_CH0_OUTPUT;                // [R17]
            alt_oe[P9+7]  = 1'b1;
        end
        case (pair(P9+8))
            pin_mux_pkg::SEL_01: begin
                alt_out[P9+8] = CSI1_DATA_OUT;                  // [R18]
                alt_oe[P9+8]  = 1'b1;
            end
            pin_mux_pkg::SEL_11: begin
                alt_out[P9+8] = TIMER_B0_CH3_OUTPUT;            // [R18]
                alt_oe[P9+8]  = 1'b1;
            end
            default: ;
        endcase
        case (pair(P9+9))
            pin_mux_pkg::SEL_01: begin
                alt_out[P9+9] = CSI1_SERIAL_CLOCK_OUT;          // [R19]
                alt_oe[P9+9]  = CSI1_SERIAL_CLOCK_OE;           // [R19]
            end
            pin_mux_pkg::SEL_11: begin
                alt_out[P9+9] = TIMER_B0_CH0_OUTPUT;            // [R19]
                alt_oe[P9+9]  = 1'b1;
            end
            default: ;
        endcase
        // Debug takeover overrides mode and selects of 5.3..5.5
        if (debug_pin_takeover_reg) begin
            alt_sel[P5+5:P5+3] = 3'b111;                        // [R2]
            alt_out[P5+5:P5+3] = {2'b00, DEBUG_DATA_OUT};       // [R2]
            alt_oe[P5+5:P5+3]  = 3'b001;                        // [R2]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < pin_mux_pkg::PIN_W; gi++) begin : g_pin
            pin_cell u_pin (
                .CLK_SYS    (CLK_SYS),
                .RST_B      (RST_B),
                .CE         (CE),
                .pad_in     (PAD_IN[gi]),
                .alt_sel    (alt_sel[gi]),
                .alt_out    (alt_out[gi]),
                .alt_oe     (alt_oe[gi]),
                .port_dir   (dir_vec[gi]),
                .port_latch (latch_vec[gi]),
                .pad_level  (level_vec[gi]),
                .pad_out    (PAD_OUT[gi]),
                .pad_oe     (PAD_OE[gi])
            );
        end
    endgenerate

    // Inputs handed to peripherals; deselected inputs rest at 0, UART rx at 1
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            KEY_RETURN <= 8'h00;
        end else if (CE) begin
            KEY_RETURN[2:0] <= 3'b000;
            KEY_RETURN[3] <= mode_vec[P5+3] && !debug_pin_takeover_reg
                && pair(P5+3) == pin_mux_pkg::SEL_00 && level_vec[P5+3]; // [R1]
            KEY_RETURN[4] <= mode_vec[P5+4] && !debug_pin_takeover_reg
                && pair(P5+4) == pin_mux_pkg::SEL_00 && level_vec[P5+4]; // [R3]
            KEY_RETURN[5] <= mode_vec[P5+5] && !debug_pin_takeover_reg
                && pair(P5+5) == pin_mux_pkg::SEL_00 && level_vec[P5+5]; // [R4]
            KEY_RETURN[6] <= mode_vec[P9] && pair(P9) == pin_mux_pkg::SEL_01
                && level_vec[P9];                                       // [R12]
            // Both 01 and 10 feed key-return 7
            KEY_RETURN[7] <= mode_vec[P9+1] && level_vec[P9+1]
                && (pair(P9+1) == pin_mux_pkg::SEL_01
                    || pair(P9+1) == pin_mux_pkg::SEL_10);              // [R13]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            TIMER_B0_CH0_INPUT <= 1'b0;
            TIMER_B0_CH3_INPUT <= 1'b0;
            TIMER_B1_CH_INPUT  <= 4'h0;
            TIMER_B2_CH_INPUT  <= 4'h0;
            TIMER_A2_CH0_INPUT <= 1'b0;
            TIMER_A2_CH1_INPUT <= 1'b0;
        end else if (CE) begin
            TIMER_B0_CH0_INPUT <=
                (mode_vec[P5+3] && !debug_pin_takeover_reg
                 && pair(P5+3) == pin_mux_pkg::SEL_01 && level_vec[P5+3]) // [R1]
                || (mode_vec[P9+9] && pair(P9+9) == pin_mux_pkg::SEL_10
                    && level_vec[P9+9]);                                 // [R19]
            TIMER_B0_CH3_INPUT <= mode_vec[P9+8]
                && pair(P9+8) == pin_mux_pkg::SEL_10 && level_vec[P9+8]; // [R18]
            for (int c = 0; c < 4; c++) begin
                TIMER_B1_CH_INPUT[(c+1)%4] <= mode_vec[P9+2+c]
                    && pair(P9+2+c) == pin_mux_pkg::SEL_01
                    && level_vec[P9+2+c];                               // [R15]
                TIMER_B2_CH_INPUT[c] <= mode_vec[P6+10+c]
                    && !fsl_vec[P6+10+c] && level_vec[P6+10+c];         // [R6]
            end
            TIMER_A2_CH0_INPUT <= mode_vec[P9+7]
                && pair(P9+7) == pin_mux_pkg::SEL_10 && level_vec[P9+7]; // [R17]
            TIMER_A2_CH1_INPUT <= mode_vec[P9+6]
                && pair(P9+6) == pin_mux_pkg::SEL_10 && level_vec[P9+6]; // [R16]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            UART1_RECEIVE_PIN    <= 1'b1;
            UART3_RECEIVE_PIN    <= 1'b1;
            EXT_INTERRUPT        <= 4'h0;
            CSI1_DATA_IN         <= 1'b0;
            CSI1_SERIAL_CLOCK_IN <= 1'b0;
        end else if (CE) begin
            UART1_RECEIVE_PIN <= !(mode_vec[P9+1]
                && pair(P9+1) == pin_mux_pkg::SEL_10) || level_vec[P9+1]; // [R13]
            // Shared pin also feeds interrupt 14; software keeps one idle
            UART3_RECEIVE_PIN <= !mode_vec[P8] || level_vec[P8];        // [R8]
            EXT_INTERRUPT[3]  <= mode_vec[P8] && level_vec[P8];         // [R8]
            for (int c = 0; c < 3; c++) begin
                EXT_INTERRUPT[c] <= mode_vec[P6+c] && fsl_vec[P6+c]
                    && level_vec[P6+c];                                 // [R5]
            end
            CSI1_DATA_IN <= mode_vec[P9+7]
                && pair(P9+7) == pin_mux_pkg::SEL_01 && level_vec[P9+7]; // [R17]
            CSI1_SERIAL_CLOCK_IN <= mode_vec[P9+9]
                && pair(P9+9) == pin_mux_pkg::SEL_01 && level_vec[P9+9]; // [R19]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            DEBUG_CLOCK_IN       <= 1'b0;
            DEBUG_MODE_SELECT_IN <= 1'b0;
            DEBUG_PIN_TAKEOVER   <= pin_mux_pkg::RST_DEBUG;
            ANALOG_INPUT_SEL     <= pin_mux_pkg::RST_MODE;
        end else if (CE) begin
            DEBUG_CLOCK_IN       <= debug_pin_takeover_reg
                                    && level_vec[P5+4];                 // [R2]
            DEBUG_MODE_SELECT_IN <= debug_pin_takeover_reg
                                    && level_vec[P5+5];                 // [R2]
            DEBUG_PIN_TAKEOVER   <= debug_pin_takeover_reg;
            ANALOG_INPUT_SEL     <= mode_vec[P7 +: PW];                 // [R7]
        end
    end

endmodule

`default_nettype wire

// File: core/pin_mux_pkg.sv
// Constants shared by the port alternate-function multiplexer
package pin_mux_pkg;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int NUM_PORT = 5;
    localparam int PORT_W   = 16;
    localparam int PIN_W    = NUM_PORT * PORT_W;

    // Byte address = port slot * PORT_STRIDE + field offset
    localparam logic [7:0] PORT_STRIDE = 8'h20;
    localparam logic [4:0] OFS_MODE    = 5'h00;
    localparam logic [4:0] OFS_FSL     = 5'h04;
    localparam logic [4:0] OFS_FSH     = 5'h08;
    localparam logic [4:0] OFS_DIR     = 5'h0C;
    localparam logic [4:0] OFS_LATCH   = 5'h10;
    localparam logic [4:0] OFS_LEVEL   = 5'h14;
    localparam logic [7:0] OFS_DEBUG   = 8'hA0;

    // Slots: 0 = port 5, 1 = port 6, 2 = port 7, 3 = port 8, 4 = port 9
    localparam logic [2:0] SLOT_P5 = 3'h0;
    localparam logic [2:0] SLOT_P9 = 3'h4;

    // First pin index of each port in the flat pin vector
    localparam int BASE_P5 = 0;
    localparam int BASE_P6 = 16;
    localparam int BASE_P7 = 32;
    localparam int BASE_P8 = 48;
    localparam int BASE_P9 = 64;

    // Pins that exist on each port
    localparam logic [PIN_W-1:0] PIN_PRESENT = {
        16'h03FF, 16'h0003, 16'hFFFF, 16'h3C07, 16'h0038
    };

    localparam logic [PORT_W-1:0] RST_MODE  = 16'h0000;
    localparam logic [PORT_W-1:0] RST_FSEL  = 16'h0000;
    localparam logic [PORT_W-1:0] RST_DIR   = 16'hFFFF;
    localparam logic [PORT_W-1:0] RST_LATCH = 16'h0000;
    localparam logic              RST_DEBUG = 1'b0;

    // Function-select pair {high, low}
    typedef enum logic [1:0] {
        SEL_00 = 2'b00,
        SEL_01 = 2'b01,
        SEL_10 = 2'b10,
        SEL_11 = 2'b11
    } fsel_t;

endpackage

// File: core/pin_cell.sv
// One pad: input synchroniser and registered output/enable selection
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
    input  wire logic CLK_SYS,
    input  wire logic RST_B,
    input  wire logic CE,
    input  wire logic pad_in,
    input  wire logic alt_sel,
    input  wire logic alt_out,
    input  wire logic alt_oe,
    input  wire logic port_dir,
    input  wire logic port_latch,
    output var  logic pad_level,
    output var  logic pad_out,
    output var  logic pad_oe
);

    logic sync_stage_reg;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            sync_stage_reg <= 1'b0;
            pad_level      <= 1'b0;
        end else if (CE) begin
            sync_stage_reg <= pad_in;
            pad_level      <= sync_stage_reg;
        end
    end

    // Direction bit 1 means input
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (CE) begin
            if (alt_sel) begin
                pad_out <= alt_out;                 // [R20]
                pad_oe  <= alt_oe;                  // [R20]
            end else begin
                pad_out <= port_latch;              // [R22]
                pad_oe  <= ~port_dir;               // [R22]
            end
        end
    end

endmodule

`default_nettype wire

// File: sim/pin_env_model.sv
// Board side of the pads: resolves each pad from both drivers
`timescale 1ns/1ps
`default_nettype none
module pin_env_model (
    input  wire logic [79:0] pad_out,
    input  wire logic [79:0] pad_oe,
    input  wire logic [79:0] ext_drv,
    output var  logic [79:0] pad_in
);
    // Board level only where the device lets go
    always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv);
endmodule
`default_nettype wire

// File: sim/port_alt_function_mux_assertions.sv
// Port-level assertions for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker (
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    input wire logic        CE,
    input wire logic [79:0] PAD_IN,
    input wire logic [79:0] PAD_OUT,
    input wire logic [79:0] PAD_OE,
    input wire logic        DEBUG_DATA_OUT,
    input wire logic        DEBUG_PIN_TAKEOVER,
    input wire logic [7:0]  KEY_RETURN,
    input wire logic [3:0]  EXT_INTERRUPT,
    input wire logic        UART3_RECEIVE_PIN,
    input wire logic [15:0] ANALOG_INPUT_SEL,
    input wire logic        TIMER_B0_CH0_INPUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B || !CE);
    a_dbg_pad_own: assert property (DEBUG_PIN_TAKEOVER [*3] |->
        PAD_OE[5:3] == 3'h1) else $error("debug pad enables");
    a_dbg_data_out: assert property (DEBUG_PIN_TAKEOVER [*3] |->
        PAD_OUT[3] == $past(DEBUG_DATA_OUT)) else $error("debug data");
    a_dbg_keys_off: assert property (DEBUG_PIN_TAKEOVER [*3] |->
        KEY_RETURN[5:3] == 3'h0) else $error("debug keys");
    a_rx3_irq_pair: assert property (EXT_INTERRUPT[3] |->
        UART3_RECEIVE_PIN) else $error("rx3 and irq14 differ");
    a_rx3_pad_src: assert property (!UART3_RECEIVE_PIN |->
        !$past(PAD_IN[48], 3)) else $error("rx3 source");
    a_analog_no_drive: assert property ((ANALOG_INPUT_SEL &
        $past(ANALOG_INPUT_SEL) & PAD_OE[47:32]) == 16'h0000)
        else $error("analogue pad driven");
    a_b0_input_src: assert property (TIMER_B0_CH0_INPUT |->
        $past(PAD_IN[3], 3) || $past(PAD_IN[73], 3))
        else $error("timer input source");
    a_key3_src: assert property (KEY_RETURN[3] |->
        $past(PAD_IN[3], 3)) else $error("key 3 source");
endmodule
bind port_alt_function_mux pin_mux_checker u_chk (.*);
`default_nettype wire

// File: sim/tb.sv
// Directed bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic CLK_SYS = '0, RST_B = '0, WR = '0, RD = '0, DEBUG_DATA_OUT = '0;
    logic [7:0] ADDR = '0, KEY_RETURN;
    logic [31:0] WDATA = '0, RDATA;
    logic [79:0] PAD_IN, PAD_OUT, PAD_OE, ext = '0;
    logic [3:0] TIMER_B1_CH_OUTPUT = '0, TIMER_B2_CH_OUTPUT = '0;
    logic TIMER_B0_CH0_OUTPUT = '0, TIMER_B0_CH3_OUTPUT = '0;
    logic MOTOR_BOTTOM_PHASE2_OUT = '0, MOTOR_TOP_PHASE3_OUT = '0;
    logic MOTOR_BOTTOM_PHASE3_OUT = '0, TIMER_A2_CH0_OUTPUT = '0;
    logic TIMER_A2_CH1_OUTPUT = '0, UART1_TRANSMIT_PIN = '0;
    logic UART3_TRANSMIT_PIN = '0, CSI1_DATA_OUT = '0;
    logic CSI1_SERIAL_CLOCK_OUT = '0, CSI1_SERIAL_CLOCK_OE = '0;
    logic TIMER_B0_CH0_INPUT, TIMER_B0_CH3_INPUT, TIMER_A2_CH0_INPUT;
    logic TIMER_A2_CH1_INPUT, UART1_RECEIVE_PIN, UART3_RECEIVE_PIN;
    logic CSI1_DATA_IN, CSI1_SERIAL_CLOCK_IN, DEBUG_CLOCK_IN;
    logic DEBUG_MODE_SELECT_IN, DEBUG_PIN_TAKEOVER;
    logic [3:0] TIMER_B1_CH_INPUT, TIMER_B2_CH_INPUT, EXT_INTERRUPT;
    logic [15:0] ANALOG_INPUT_SEL;
    int miscompares = 0, checks_done = 0;
    always #4 CLK_SYS = ~CLK_SYS;
    port_alt_function_mux dut (.*, .CE(1'b1));
    pin_env_model env (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .ext_drv(ext),
        .pad_in(PAD_IN));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK_SYS);
        WR    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK_SYS);
        RD   <= 1'b0;
        #1 chk(RDATA, e);
    endtask
    // Two pad stages plus margin
    task automatic settle;
        repeat (5) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #160000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        rd_chk(8'h8C, 32'h0000FFFF);
        rd_chk(8'hFC, 32'h0);
        wr_reg(8'h8C, 32'h0000FFFE);
        wr_reg(8'h90, 32'h00000001);
        settle;
        chk({PAD_OE[64], PAD_OUT[64]}, 2'b11);
        wr_reg(8'h88, 32'h00000001);
        wr_reg(8'h80, 32'h00000001);
        settle;
        chk({PAD_OE[64], PAD_OUT[64]}, 2'b10);
        $display("test port 9.0 done");
        wr_reg(8'h84, 32'h00000200);
        wr_reg(8'h88, 32'h00000201);
        wr_reg(8'h80, 32'h00000201);
        @(posedge CLK_SYS) TIMER_B0_CH0_OUTPUT <= 1'b1;
        ext[73] <= 1'b1;
        settle;
        chk({PAD_OE[73], PAD_OUT[73]}, 2'b11);
        wr_reg(8'h84, 32'h0);
        settle;
        chk({PAD_OE[73], TIMER_B0_CH0_INPUT}, 2'b01);
        wr_reg(8'h80, 32'h00000001);
        $display("test port 9.9 done");
        @(posedge CLK_SYS) ext[3] <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            wr_reg(8'h04, {28'h0, p[0], 3'b000});
            wr_reg(8'h08, {28'h0, p[1], 3'b000});
            wr_reg(8'h00, 32'h00000008);
            settle;
            chk({PAD_OE[3], KEY_RETURN[3], TIMER_B0_CH0_INPUT},
                {p[1], p == 0, p == 1});
        end
        $display("test port 5.3 done");
        @(posedge CLK_SYS) ext[4] <= 1'b1;
        wr_reg(8'hA0, 32'h1);
        @(posedge CLK_SYS) DEBUG_DATA_OUT <= 1'b1;
        settle;
        chk({PAD_OE[5:3], PAD_OUT[3], DEBUG_CLOCK_IN}, 5'b00111);
        wr_reg(8'hA0, 32'h0);
        $display("test debug done");
        // UART3 transmit on 8.1; 8.0 feeds receiver and interrupt 14 together
        wr_reg(8'h60, 32'h3);
        @(posedge CLK_SYS) UART3_TRANSMIT_PIN <= 1'b1;
        settle;
        chk({PAD_OE[49:48], PAD_OUT[49], UART3_RECEIVE_PIN}, 4'hA);
        @(posedge CLK_SYS) ext[48] <= 1'b1;
        settle;
        chk({UART3_RECEIVE_PIN, EXT_INTERRUPT[3]}, 2'b11);
        wr_reg(8'h4C, 32'h0);
        wr_reg(8'h40, 32'h8001);
        settle;
        chk({ANALOG_INPUT_SEL, PAD_OE[47:32]}, 32'h80017FFE);
        wr_reg(8'h84, 32'h3FF);
        wr_reg(8'h88, 32'h0);
        wr_reg(8'h80, 32'h3FF);
        ext[79:64] <= 16'h0287;
        settle;
        chk({KEY_RETURN[7:6], TIMER_B1_CH_INPUT, CSI1_DATA_IN,
            CSI1_SERIAL_CLOCK_IN}, 8'hCB);
        wr_reg(8'h00, 32'hFFFF);
        rd_chk(8'h00, 32'h38);
        $display("test ports 7 8 9 done");
        report_and_stop;
    end
endmodule
`default_nettype wire
